// ---- hw/osms_top.sv ----
// Oscillator mode select: AHB-Lite register slave, primary mode decode, pin ownership,
// divided clock output, trim and multiplier control, and the system clock selector.
// Assumes oscillator waveforms arrive as asynchronous square waves far slower than hclk.
//
// Notes on behaviour
// - External clock uses input pin, frees output.
// - External clock has low, medium, high power.
// - External clock skips the startup counter.
// - Logic static; stopped clock halts, keeps state.
// - Crystal modes select increasing amplifier gain.
// - High gain has medium and high power.
// - Resistor-capacitor mode drives input-clock divided four.
// - Resistor-capacitor I/O mode frees output pin.
// - Three internal oscillators; slowest is untrimmed.
// - Frequency select sets internal output frequency.
// - Two-bit source select picks system clock.
// - Two internal primary codes; input pin GPIO.
// - Trim is six-bit signed, resets zero.
// - Trim applies live; no completion flag.
// - Trim leaves low frequency oscillator alone.
// - Low source bit picks slow internal clock.
// - Multiplier enable covers all primary sources.
// - Slow clock from fast oscillator or low.
// - Multiplier multiplies input clock by four.
// - Source 1x internal, 01 secondary, 00 primary.
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "osms_defs.svh"

module osms_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic osc_input_pin_in,
  input wire logic sec_osc_in,
  input wire logic hf_osc_in,
  input wire logic mf_osc_in,
  input wire logic lf_osc_in,
  input wire logic port_a_bit7_out,
  input wire logic port_a_bit7_oe,
  input wire logic port_in_pin_out,
  input wire logic port_in_pin_oe,
  output logic osc_input_pin_out,
  output logic osc_input_pin_oe,
  output logic osc_output_pin_out,
  output logic osc_output_pin_oe,
  output logic osc_in_port_owned,
  output logic osc_out_port_owned,
  output logic sys_clk_tick,
  output logic [1:0] sys_source_active,
  output logic [2:0] amp_gain,
  output logic [1:0] ext_power,
  output logic startup_counter_bypass,
  output logic [5:0] hf_trim,
  output logic [5:0] mf_trim,
  output logic multiplier_on
);

  localparam int NSYNC = 5;

  logic [7:0] ctrl_ff;
  logic [4:0] cfg_ff;
  logic [7:0] trim_ff;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] sync3_ff;
  logic [NSYNC-1:0] tick;
  logic pin_tick;
  logic sec_tick;
  logic int_tick;
  logic addr_phase;
  logic [7:0] stat_val;
  logic [1:0] mux_sel;
  logic [2:0] src_tick;
  logic base_tick;
  logic div4_cnt_ff;
  logic divided_clock_output_ff;
  logic [4:0] ctrl_freq_prev_ff;
  logic freq_change;
  logic drives_divided_clock_output;
  logic pin_is_clock;
  osms_pkg::osms_mode_t mode;

  // Primary configuration code to mode; unlisted codes fall back to external clock.
  function automatic osms_pkg::osms_mode_t osms_decode(input logic [3:0] code);
    osms_pkg::osms_mode_t m;
    m = osms_pkg::OSMS_MODE_EXT_CLOCK;
    case (code)
      `OSMS_CODE_LOW_GAIN: m = osms_pkg::OSMS_MODE_LOW_GAIN;
      `OSMS_CODE_MED_GAIN: m = osms_pkg::OSMS_MODE_MED_GAIN;
      `OSMS_CODE_HIGH_GAIN_HP: m = osms_pkg::OSMS_MODE_HIGH_GAIN;
      `OSMS_CODE_HIGH_GAIN_MP: m = osms_pkg::OSMS_MODE_HIGH_GAIN;
      `OSMS_CODE_RC: m = osms_pkg::OSMS_MODE_RC;
      `OSMS_CODE_RC_IO: m = osms_pkg::OSMS_MODE_RC_IO;
      `OSMS_CODE_INT_IO: m = osms_pkg::OSMS_MODE_INT_IO;
      `OSMS_CODE_INT_DIVIDED_CLOCK_OUTPUT: m = osms_pkg::OSMS_MODE_INT_DIVIDED_CLOCK_OUTPUT;
      default: m = osms_pkg::OSMS_MODE_EXT_CLOCK;
    endcase
    return m;
  endfunction : osms_decode

  // Source select to mux index: 1x internal, 01 secondary, 00 primary.
  function automatic logic [1:0] osms_src_idx(input logic [1:0] scs, input logic pri_int);
    logic [1:0] idx;
    idx = `OSMS_SRC_PIN;
    if (scs[1])
      idx = `OSMS_SRC_INT;
    else if (scs[0])
      idx = `OSMS_SRC_SEC;
    else if (pri_int)
      idx = `OSMS_SRC_INT;
    return idx;
  endfunction : osms_src_idx

  // ---------------- AHB-Lite slave, zero wait states ----------------
  assign addr_phase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= addr_phase && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // Read data is captured at the address phase so it stands in the data phase from a flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h00000000;
    else if (addr_phase && !hwrite)
    begin
      case (haddr[7:0])
        `OSMS_OFS_CTRL: hrdata_ff <= {24'h000000, ctrl_ff};
        `OSMS_OFS_CFG: hrdata_ff <= {27'h0000000, cfg_ff};
        `OSMS_OFS_TRIM: hrdata_ff <= {24'h000000, trim_ff};
        `OSMS_OFS_STAT: hrdata_ff <= {24'h000000, stat_val};
        default: hrdata_ff <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_ff <= `OSMS_CTRL_RST;
    else if (wr_pend_ff && wr_addr_ff == `OSMS_OFS_CTRL)
      ctrl_ff <= {1'b0, hwdata[6:3], 1'b0, hwdata[1:0]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg_ff <= `OSMS_CFG_RST;
    else if (wr_pend_ff && wr_addr_ff == `OSMS_OFS_CFG)
      cfg_ff <= hwdata[4:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trim_ff <= `OSMS_TRIM_RST;
    else if (wr_pend_ff && wr_addr_ff == `OSMS_OFS_TRIM)
      trim_ff <= hwdata[7:0];
  end

  // ---------------- Oscillator input synchronisers ----------------
  assign raw = {lf_osc_in, mf_osc_in, hf_osc_in, sec_osc_in, osc_input_pin_in};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
          sync3_ff[g] <= 1'b0;
        end
        else
        begin
          sync1_ff[g] <= raw[g];
          sync2_ff[g] <= sync1_ff[g];
          sync3_ff[g] <= sync2_ff[g];
        end
      end
      assign tick[g] = sync2_ff[g] & ~sync3_ff[g];
    end
  endgenerate

  assign sec_tick = tick[1];

  // ---------------- Primary mode decode ----------------
  assign mode = osms_decode(cfg_ff[3:0]);

  assign pin_is_clock = (mode != osms_pkg::OSMS_MODE_INT_IO)
    && (mode != osms_pkg::OSMS_MODE_INT_DIVIDED_CLOCK_OUTPUT);
  assign pin_tick = pin_is_clock & tick[0];

  always_comb
  begin
    amp_gain = `OSMS_GAIN_OFF;
    ext_power = `OSMS_PWR_NONE;
    case (mode)
      osms_pkg::OSMS_MODE_LOW_GAIN: amp_gain = `OSMS_GAIN_LOW;
      osms_pkg::OSMS_MODE_MED_GAIN: amp_gain = `OSMS_GAIN_MED;
      osms_pkg::OSMS_MODE_HIGH_GAIN:
        amp_gain = (cfg_ff[3:0] == `OSMS_CODE_HIGH_GAIN_HP) ? `OSMS_GAIN_HIGH_HP
          : `OSMS_GAIN_HIGH_MP;
      osms_pkg::OSMS_MODE_EXT_CLOCK:
      begin
        if (cfg_ff[3:0] == `OSMS_CODE_EXT_HP)
          ext_power = `OSMS_PWR_HIGH;
        else if (cfg_ff[3:0] == `OSMS_CODE_EXT_MP)
          ext_power = `OSMS_PWR_MED;
        else
          ext_power = `OSMS_PWR_LOW;
      end
      default:
      begin
        amp_gain = `OSMS_GAIN_OFF;
        ext_power = `OSMS_PWR_NONE;
      end
    endcase
  end

  assign startup_counter_bypass = (mode != osms_pkg::OSMS_MODE_LOW_GAIN)
    && (mode != osms_pkg::OSMS_MODE_MED_GAIN) && (mode != osms_pkg::OSMS_MODE_HIGH_GAIN);

  // ---------------- Internal block, trim and multiplier ----------------
  // trim applies live
  assign hf_trim = trim_ff[5:0];
  assign mf_trim = trim_ff[5:0];

  osms_int_div u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .hf_tick(tick[2]),
    .mf_tick(tick[3]),
    .lf_tick(tick[4]),
    .freq_sel(ctrl_ff[6:4]),
    .mf_select(ctrl_ff[`OSMS_CTRL_MFSEL_BIT]),
    .low_freq_source_select(trim_ff[`OSMS_TRIM_LFSEL_BIT]),
    .int_tick(int_tick)
  );

  assign multiplier_on = (trim_ff[`OSMS_TRIM_MULT_BIT] || (cfg_ff[`OSMS_CFG_MULT_BIT]
    && pin_is_clock)) && (mux_sel != `OSMS_SRC_SEC);

  // ---------------- System clock selection ----------------
  // source decode
  assign mux_sel = osms_src_idx(ctrl_ff[1:0], !pin_is_clock);
  assign src_tick = {int_tick, sec_tick, pin_tick};

  // A frequency change reroutes the internal divider, so the selector re-syncs on it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_freq_prev_ff <= 5'h06;
    else
      ctrl_freq_prev_ff <= {trim_ff[`OSMS_TRIM_LFSEL_BIT], ctrl_ff[6:3]};
  end
  // The medium select bit reroutes the divider as well, so it counts as a frequency change.
  assign freq_change = ctrl_freq_prev_ff != {trim_ff[`OSMS_TRIM_LFSEL_BIT], ctrl_ff[6:3]};

  osms_clk_mux u_mux (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_tick(src_tick),
    .sel(mux_sel),
    .restart(freq_change && mux_sel == `OSMS_SRC_INT),
    .sys_tick_ff(sys_clk_tick),
    .active_ff(sys_source_active)
  );

  // ---------------- Divided clock output ----------------
  // RC pin clock, or system clock in internal divided mode, over four
  assign drives_divided_clock_output = (mode == osms_pkg::OSMS_MODE_RC)
    || (mode == osms_pkg::OSMS_MODE_INT_DIVIDED_CLOCK_OUTPUT);
  assign base_tick = (mode == osms_pkg::OSMS_MODE_RC) ? pin_tick : sys_clk_tick;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div4_cnt_ff <= 1'b0;
      divided_clock_output_ff <= 1'b0;
    end
    else if (!drives_divided_clock_output)
    begin
      div4_cnt_ff <= 1'b0;
      divided_clock_output_ff <= 1'b0;
    end
    else if (base_tick)
    begin
      div4_cnt_ff <= ~div4_cnt_ff;
      if (div4_cnt_ff)
        divided_clock_output_ff <= ~divided_clock_output_ff;
    end
  end

  // ---------------- Pin ownership ----------------
  // unused pins to port
  assign osc_out_port_owned = (mode == osms_pkg::OSMS_MODE_EXT_CLOCK)
    || (mode == osms_pkg::OSMS_MODE_RC_IO) || (mode == osms_pkg::OSMS_MODE_INT_IO);
  assign osc_in_port_owned = !pin_is_clock;

  // Crystal modes leave both pins to the analog amplifier, so logic never drives them.
  assign osc_output_pin_out = drives_divided_clock_output ? divided_clock_output_ff
    : (osc_out_port_owned & port_a_bit7_out);
  assign osc_output_pin_oe = drives_divided_clock_output | (osc_out_port_owned & port_a_bit7_oe);
  assign osc_input_pin_out = osc_in_port_owned & port_in_pin_out;
  assign osc_input_pin_oe = osc_in_port_owned & port_in_pin_oe;

  assign stat_val = {multiplier_on, startup_counter_bypass, osc_out_port_owned,
    osc_in_port_owned, drives_divided_clock_output, (`OSMS_MULT_FACTOR == 3'h4), sys_source_active};

endmodule : osms_top

// ---- hw/osms_defs.svh ----
// Register offsets, field positions, reset values and config codes of the oscillator mode block.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
`ifndef OSMS_DEFS_SVH
`define OSMS_DEFS_SVH

`define OSMS_OFS_CTRL 8'h00
`define OSMS_OFS_CFG 8'h04
`define OSMS_OFS_TRIM 8'h08
`define OSMS_OFS_STAT 8'h0C

`define OSMS_CTRL_SRC_LSB 0
`define OSMS_CTRL_MFSEL_BIT 3
`define OSMS_CTRL_FREQ_LSB 4
`define OSMS_CTRL_RST 8'h30

`define OSMS_CFG_CODE_LSB 0
`define OSMS_CFG_MULT_BIT 4
`define OSMS_CFG_RST 5'h08

`define OSMS_TRIM_LSB 0
`define OSMS_TRIM_MULT_BIT 6
`define OSMS_TRIM_LFSEL_BIT 7
`define OSMS_TRIM_RST 8'h00

`define OSMS_CODE_LOW_GAIN 4'h0
`define OSMS_CODE_MED_GAIN 4'h1
`define OSMS_CODE_HIGH_GAIN_HP 4'h2
`define OSMS_CODE_HIGH_GAIN_MP 4'h3
`define OSMS_CODE_EXT_HP 4'h4
`define OSMS_CODE_EXT_MP 4'h5
`define OSMS_CODE_RC 4'h6
`define OSMS_CODE_RC_IO 4'h7
`define OSMS_CODE_INT_IO 4'h8
`define OSMS_CODE_INT_DIVIDED_CLOCK_OUTPUT 4'h9

`define OSMS_GAIN_OFF 3'h0
`define OSMS_GAIN_LOW 3'h1
`define OSMS_GAIN_MED 3'h2
`define OSMS_GAIN_HIGH_MP 3'h3
`define OSMS_GAIN_HIGH_HP 3'h4

`define OSMS_PWR_NONE 2'h0
`define OSMS_PWR_LOW 2'h1
`define OSMS_PWR_MED 2'h2
`define OSMS_PWR_HIGH 2'h3

`define OSMS_SRC_PIN 2'h0
`define OSMS_SRC_SEC 2'h1
`define OSMS_SRC_INT 2'h2

`define OSMS_MULT_FACTOR 3'h4

`endif

// ---- hw/osms_pkg.sv ----
// Types shared by the oscillator mode select files.
// Assumes nothing beyond a SystemVerilog tool.
package osms_pkg;

  typedef enum logic [7:0] {
    OSMS_MODE_LOW_GAIN = 8'h01,
    OSMS_MODE_MED_GAIN = 8'h02,
    OSMS_MODE_HIGH_GAIN = 8'h04,
    OSMS_MODE_EXT_CLOCK = 8'h08,
    OSMS_MODE_RC = 8'h10,
    OSMS_MODE_RC_IO = 8'h20,
    OSMS_MODE_INT_IO = 8'h40,
    OSMS_MODE_INT_DIVIDED_CLOCK_OUTPUT = 8'h80
  } osms_mode_t;

  typedef enum logic [1:0] {
    OSMS_MUX_RUN = 2'h1,
    OSMS_MUX_HOLD = 2'h2
  } osms_mux_state_t;

endpackage : osms_pkg

// ---- hw/osms_int_div.sv ----
// Internal oscillator divider: turns high, medium and low frequency ticks into the eight
// selectable internal frequencies. Assumes ticks are one-cycle pulses on hclk.
`timescale 1ns/1ps
`include "osms_defs.svh"

module osms_int_div (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hf_tick,
  input wire logic mf_tick,
  input wire logic lf_tick,
  input wire logic [2:0] freq_sel,
  input wire logic mf_select,
  input wire logic low_freq_source_select,
  output logic int_tick
);

  logic [8:0] hf_cnt_ff;
  logic [3:0] mf_cnt_ff;
  logic [9:0] hf_div;
  logic mf_div1;
  logic mf_div2;
  logic mf_div16;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hf_cnt_ff <= 9'h000;
    else if (hf_tick)
      hf_cnt_ff <= hf_cnt_ff + 9'h001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mf_cnt_ff <= 4'h0;
    else if (mf_tick)
      mf_cnt_ff <= mf_cnt_ff + 4'h1;
  end

  // A tick of divide-by-2^k is the source tick that wraps the low k counter bits.
  assign hf_div[0] = hf_tick;
  genvar k;
  generate
    for (k = 1; k < 10; k++)
    begin : g_div
      assign hf_div[k] = hf_tick & (&hf_cnt_ff[k-1:0]);
    end
  endgenerate

  assign mf_div1 = mf_tick;
  assign mf_div2 = mf_tick & mf_cnt_ff[0];
  assign mf_div16 = mf_tick & (&mf_cnt_ff);

  always_comb
  begin
    int_tick = 1'b0;
    case (freq_sel)
      3'h7: int_tick = hf_div[0];
      3'h6: int_tick = hf_div[1];
      3'h5: int_tick = hf_div[2];
      3'h4: int_tick = hf_div[3];
      3'h3: int_tick = hf_div[4];
      3'h2: int_tick = mf_select ? mf_div1 : hf_div[5];
      3'h1: int_tick = mf_select ? mf_div2 : hf_div[6];
      3'h0:
      begin
        if (!low_freq_source_select)
          int_tick = lf_tick;
        else
          int_tick = mf_select ? mf_div16 : hf_div[9];
      end
      default: int_tick = 1'b0;
    endcase
  end

endmodule : osms_int_div

// ---- hw/osms_clk_mux.sv ----
// Glitch-free system clock selector over tick sources.
// Assumes sources are one-cycle pulses on hclk; a silent source simply stalls the output.
`timescale 1ns/1ps

module osms_clk_mux (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] src_tick,
  input wire logic [1:0] sel,
  input wire logic restart,
  output logic sys_tick_ff,
  output logic [1:0] active_ff
);

  osms_pkg::osms_mux_state_t state_ff;
  logic [1:0] want_ff;
  logic new_tick;

  assign new_tick = src_tick[want_ff];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      want_ff <= 2'h2;
    else
      want_ff <= sel;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= osms_pkg::OSMS_MUX_RUN;
    else
    begin
      case (state_ff)
        osms_pkg::OSMS_MUX_RUN:
          if (sel != want_ff || restart)
            state_ff <= osms_pkg::OSMS_MUX_HOLD;
        osms_pkg::OSMS_MUX_HOLD:
          if (new_tick && sel == want_ff && !restart)
            state_ff <= osms_pkg::OSMS_MUX_RUN;
        default: state_ff <= osms_pkg::OSMS_MUX_RUN;
      endcase
    end
  end

  // The first new-source tick only re-arms the output, so no short period is emitted.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      active_ff <= 2'h2;
    else if (state_ff == osms_pkg::OSMS_MUX_HOLD && new_tick && sel == want_ff && !restart)
      active_ff <= want_ff;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sys_tick_ff <= 1'b0;
    else
      sys_tick_ff <= (state_ff == osms_pkg::OSMS_MUX_RUN) && src_tick[active_ff]
        && sel == want_ff && !restart;
  end

endmodule : osms_clk_mux

// ---- tb/osms_osc_model.sv ----
// Far-side model: square waves for the oscillator input pin and the four oscillator inputs.
// Assumes every half period is at least two hclk cycles, as the synchronisers need.
`timescale 1ns/1ps

module osms_osc_model #(
  parameter int PIN_HALF = 3,
  parameter int SEC_HALF = 5,
  parameter int HF_HALF = 2,
  parameter int MF_HALF = 4,
  parameter int LF_HALF = 6
) (
  input wire logic hclk,
  input wire logic pin_run,
  output logic osc_input_pin_in,
  output logic sec_osc_in,
  output logic hf_osc_in,
  output logic mf_osc_in,
  output logic lf_osc_in
);
  localparam int HALF [5] = '{PIN_HALF, SEC_HALF, HF_HALF, MF_HALF, LF_HALF};
  logic [4:0] wave = 5'h00;
  int cnt [5] = '{0, 0, 0, 0, 0};

  assign {lf_osc_in, mf_osc_in, hf_osc_in, sec_osc_in, osc_input_pin_in} = wave;

  // A stopped pin clock holds its level, as a halted external source does.
  always @(posedge hclk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (i != 0 || pin_run)
      begin
        cnt[i] = (cnt[i] + 1) % HALF[i];
        if (cnt[i] == 0)
        begin
          wave[i] <= !wave[i];
        end
      end
    end
  end
endmodule : osms_osc_model

// ---- tb/osms_top_chk.sv ----
// Checker for the oscillator mode block: pin ownership, mode decode, trim and clock pulses.
// Assumes it is bound to osms_top and sees only its ports.
`timescale 1ns/1ps
`include "osms_defs.svh"

module osms_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic port_a_bit7_out,
  input wire logic port_a_bit7_oe,
  input wire logic port_in_pin_out,
  input wire logic port_in_pin_oe,
  input wire logic osc_input_pin_out,
  input wire logic osc_input_pin_oe,
  input wire logic osc_output_pin_out,
  input wire logic osc_output_pin_oe,
  input wire logic osc_in_port_owned,
  input wire logic osc_out_port_owned,
  input wire logic sys_clk_tick,
  input wire logic [1:0] sys_source_active,
  input wire logic [2:0] amp_gain,
  input wire logic [1:0] ext_power,
  input wire logic startup_counter_bypass,
  input wire logic [5:0] hf_trim,
  input wire logic [5:0] mf_trim
);
  logic [3:0] gap_ff;
  logic wr_ff;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // The fastest source has a period of four cycles, so closer pulses are runts.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gap_ff <= 4'hF;
    else if (sys_clk_tick)
      gap_ff <= 4'h0;
    else if (gap_ff != 4'hF)
      gap_ff <= gap_ff + 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_ff <= 1'b0;
    else
      wr_ff <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == `OSMS_OFS_TRIM);
  end

  a_out_port_pass: assert property (osc_out_port_owned |-> osc_output_pin_out ==
    port_a_bit7_out && osc_output_pin_oe == port_a_bit7_oe) else $error("output pin not ported");
  a_in_port_pass: assert property (osc_in_port_owned |-> osc_input_pin_out ==
    port_in_pin_out && osc_input_pin_oe == port_in_pin_oe) else $error("input pin not ported");
  a_in_blocked: assert property (!osc_in_port_owned |-> !osc_input_pin_oe)
    else $error("input pin driven while owned by the oscillator");
  a_crystal_no_bypass: assert property (amp_gain != `OSMS_GAIN_OFF |->
    !startup_counter_bypass) else $error("crystal mode bypasses startup counter");
  a_ext_bypass: assert property (ext_power != `OSMS_PWR_NONE |-> startup_counter_bypass)
    else $error("external clock waits for startup counter");
  a_crystal_pins: assert property (amp_gain != `OSMS_GAIN_OFF |-> !osc_out_port_owned
    && !osc_in_port_owned && !osc_output_pin_oe) else $error("crystal pins not reserved");
  a_ext_frees_out: assert property (ext_power != `OSMS_PWR_NONE |-> osc_out_port_owned
    && !osc_in_port_owned && amp_gain == `OSMS_GAIN_OFF) else $error("external pin use wrong");
  a_trim_equal: assert property (hf_trim == mf_trim)
    else $error("trim differs between fast oscillators");
  a_no_runt: assert property (sys_clk_tick |-> gap_ff >= 4'h3)
    else $error("runt system clock pulse");
  a_trim_write: assert property ($changed(hf_trim) |-> $past(wr_ff))
    else $error("trim changed without a trim write");

  c_crystal: cover property (amp_gain == `OSMS_GAIN_HIGH_HP);
  c_ext_low: cover property (ext_power == `OSMS_PWR_LOW);
  c_pin_tick: cover property (sys_clk_tick && sys_source_active == `OSMS_SRC_PIN);
endmodule : osms_top_chk

bind osms_top osms_top_chk u_chk (.*);

// ---- tb/osms_test.sv ----
// Self-checking bench for the oscillator mode block: registers, mode decode, pins, clocks.
// Assumes the design under hw/ and the oscillator model and checker under tb/.
`timescale 1ns/1ps
`include "osms_defs.svh"

module osms_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic pin_run = 1'b1;
  logic port_a_bit7_out = 1'b0, port_a_bit7_oe = 1'b0, port_in_pin_out = 1'b0;
  logic port_in_pin_oe = 1'b0;
  logic hready, hreadyout, hresp, osc_input_pin_in, sec_osc_in, hf_osc_in, mf_osc_in;
  logic lf_osc_in, osc_input_pin_out, osc_input_pin_oe, osc_output_pin_out, osc_output_pin_oe;
  logic osc_in_port_owned, osc_out_port_owned, sys_clk_tick, startup_counter_bypass;
  logic multiplier_on;
  logic [1:0] sys_source_active, ext_power;
  logic [2:0] amp_gain;
  logic [5:0] hf_trim, mf_trim, t;
  logic [31:0] hrdata, rd;
  logic [7:0] cf [3] = '{8'h2A, 8'h02, 8'h0A};
  logic tr [3] = '{1'b0, 1'b0, 1'b1};
  int ex [3] = '{8, 12, 128};
  logic [8:0] mt [6] = '{9'h089, 9'h080, 9'h08A, 9'h141, 9'h0A9, 9'h040};
  int fails = 0, compares = 0, seed = 32'h246A, p, n;

  assign hready = hreadyout;
  always #50 hclk = !hclk;

  osms_top DUT (.*);
  osms_osc_model u_model (.*);

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic tick_gap(input logic divided_clock_output, output int g);
    logic prev, hit;
    prev = osc_output_pin_out;
    repeat (3)
    begin
      g = 0;
      hit = 1'b0;
      while (!hit && g < 3000)
      begin
        @(posedge hclk);
        g++;
        hit = divided_clock_output ? (osc_output_pin_out === 1'b1 && prev === 1'b0) : sys_clk_tick === 1'b1;
        prev = osc_output_pin_out;
      end
    end
  endtask : tick_gap

  // Packs {gain, power, bypass, input owned, output owned} for one primary code.
  function automatic logic [7:0] mode_exp(input logic [3:0] c);
    case (c)
      4'h0: return 8'h20;
      4'h1: return 8'h40;
      4'h2: return 8'h80;
      4'h3: return 8'h60;
      4'h4: return 8'h1D;
      4'h5: return 8'h15;
      4'h6: return 8'h04;
      4'h7: return 8'h05;
      4'h8: return 8'h07;
      4'h9: return 8'h06;
      default: return 8'h0D;
    endcase
  endfunction : mode_exp

  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  initial
  begin
    #(100 * 40000);
    fails++;
    close_out();
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    check({31'h0, hresp}, 32'h0, "bus response");
    bus(1'b0, `OSMS_OFS_CTRL, 32'h0, rd);
    check(rd, 32'h30, "ctrl reset");
    bus(1'b0, `OSMS_OFS_CFG, 32'h0, rd);
    check(rd, 32'h08, "cfg reset");
    bus(1'b0, `OSMS_OFS_TRIM, 32'h0, rd);
    check(rd, 32'h00, "trim reset");
    for (int c = 0; c < 16; c++)
    begin
      {port_a_bit7_out, port_a_bit7_oe, port_in_pin_out, port_in_pin_oe} <= 4'($random(seed));
      bus(1'b1, `OSMS_OFS_CFG, 32'(c), rd);
      bus(1'b0, `OSMS_OFS_CFG, 32'h0, rd);
      check(rd, 32'(c), "cfg readback");
      check({amp_gain, ext_power, startup_counter_bypass, osc_in_port_owned,
             osc_out_port_owned}, mode_exp(4'(c)), "mode decode");
    end
    bus(1'b1, `OSMS_OFS_CFG, 32'h8, rd);
    t = 6'($random(seed));
    bus(1'b1, `OSMS_OFS_TRIM, 32'(t), rd);
    bus(1'b0, `OSMS_OFS_TRIM, 32'h0, rd);
    check(rd, 32'(t), "trim readback");
    check({hf_trim, mf_trim}, {t, t}, "trim outputs");
    for (int f = 7; f >= 3; f--)
    begin
      bus(1'b1, `OSMS_OFS_CTRL, 32'(f << 4) | 32'h2, rd);
      tick_gap(1'b0, p);
      check(32'(p), 32'(4 << (7 - f)), "internal period");
    end
    // The medium and slow options must keep their periods whatever the trim holds.
    foreach (cf[i])
    begin
      bus(1'b1, `OSMS_OFS_TRIM, {24'h0, tr[i], 1'b0, t}, rd);
      bus(1'b1, `OSMS_OFS_CTRL, 32'(cf[i]), rd);
      tick_gap(1'b0, p);
      check(32'(p), 32'(ex[i]), "low frequency period");
    end
    bus(1'b1, `OSMS_OFS_CFG, 32'h4, rd);
    for (int s = 3; s >= 0; s--)
    begin
      bus(1'b1, `OSMS_OFS_CTRL, 32'h70 | 32'(s), rd);
      n = 0;
      while (sys_source_active !== (s > 1 ? 2'h2 : 2'(s)) && n < 400)
      begin
        @(posedge hclk);
        n++;
      end
      check(sys_source_active, s > 1 ? 2'h2 : 2'(s), "source select");
    end
    tick_gap(1'b0, p);
    check(32'(p), 32'h6, "external clock period");
    pin_run <= 1'b0;
    repeat (10) @(posedge hclk);
    n = 0;
    repeat (50)
    begin
      @(posedge hclk);
      n += sys_clk_tick;
    end
    check(32'(n), 32'h0, "halted clock");
    pin_run <= 1'b1;
    tick_gap(1'b0, p);
    check(32'(p), 32'h6, "resumed clock");
    foreach (mt[i])
    begin
      bus(1'b1, `OSMS_OFS_CFG, 32'(mt[i][8:4]), rd);
      bus(1'b1, `OSMS_OFS_TRIM, {24'h0, 1'b0, mt[i][3], 6'h0}, rd);
      bus(1'b1, `OSMS_OFS_CTRL, 32'h70 | 32'(mt[i][2:1]), rd);
      bus(1'b0, `OSMS_OFS_STAT, 32'h0, rd);
      check({multiplier_on, rd[7], rd[2]}, {mt[i][0], mt[i][0], 1'b1}, "multiplier");
    end
    bus(1'b1, `OSMS_OFS_CFG, 32'h6, rd);
    tick_gap(1'b1, p);
    check(32'(p), 32'h18, "divided clock period");
    check(osc_output_pin_oe, 1'b1, "divided clock drive");
    bus(1'b1, `OSMS_OFS_CFG, 32'h9, rd);
    tick_gap(1'b1, p);
    check(32'(p), 32'h10, "system clock over four");
    check({osc_output_pin_oe, osc_in_port_owned}, 2'h3, "clock out pins");
    close_out();
  end
endmodule : osms_test
